// file: logic/fspc_ctrl.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "fspc_map.svh"
module fspc_ctrl #(
    parameter bit VARIANT_64K = 1'b1    // 1: 64k-byte part, 0: 32k-byte part
) (
    // clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        ARST_N_IN,
    // register port
    input  wire logic [3:0]  REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    // cpu side
    input  wire logic [15:0] Z_PTR_IN,
    input  wire logic        STORE_INSTR_IN,
    input  wire logic        LOAD_INSTR_IN,
    input  wire logic        GLOBAL_IRQ_EN_IN,
    input  wire logic [1:0]  BOOT_SIZE_FUSE_IN,
    input  wire logic [7:0]  SIG_BYTE_IN,
    // flash array side
    input  wire logic        FLASH_DONE_IN,
    output logic             FLASH_ERASE_OUT,
    output logic             FLASH_WRITE_OUT,
    output logic             BUF_FILL_OUT,
    output logic      [8:0]  PAGE_SELECT_OUT,
    output logic      [6:0]  WORD_INDEX_OUT,
    output logic             LOAD_SIG_OUT,
    output logic             LOAD_HIGH_BYTE_OUT,
    output logic             SECTION_BLOCKED_OUT,
    output logic             SECTION_READ_OK_OUT,
    output logic             FLASH_READY_IRQ_OUT,
    output logic      [15:0] BOOT_RESET_ADDR_OUT
);
    // reset release chain
    logic                     rst_meta_r;
    logic                     rst_n_r;
    // control and status bits
    logic                     irq_en_r;
    logic                     busy_flag_r;
    logic                     store_en_r;
    logic [4:0]               cmd_r;          // armed low five bits
    logic                     sig_arm_r;      // signature read armed
    logic [2:0]               arm_cnt_r;      // cycles left in arm window
    fspc_pkg::fspc_state_e    state_r;
    // decoded values
    logic [15:0]              boot_start;
    logic [15:0]              unread_start;
    logic [15:0]              word_addr;
    logic                     target_readable;
    logic                     store_hit;
    logic                     load_sig_hit;
    logic                     ctrl_wr;

    // boot section start from fuses; shared by reset address and register read
    function automatic logic [15:0] boot_decode(input logic big, input logic [1:0] sz);
        logic [15:0] a;
        a = 16'h0000;
        unique case (sz)
            2'b11: a = big ? `FSPC_BOOT64_11 : `FSPC_BOOT32_11;
            2'b10: a = big ? `FSPC_BOOT64_10 : `FSPC_BOOT32_10;
            2'b01: a = big ? `FSPC_BOOT64_01 : `FSPC_BOOT32_01;
            2'b00: a = big ? `FSPC_BOOT64_00 : `FSPC_BOOT32_00;
        endcase
        return a;
    endfunction

    // boot start follows variant and fuse setting
    assign boot_start = boot_decode(VARIANT_64K, BOOT_SIZE_FUSE_IN);
    // readable section boundary is fixed per variant
    assign unread_start = VARIANT_64K ? `FSPC_UNREAD64 : `FSPC_UNREAD32;
    // word address drops pointer bit 0, which only picks the load byte;
    // the 32k part has a 14-bit counter, so pointer bit 15 is a don't-care
    // there and must not push a low address past the section edge
    assign word_addr  = VARIANT_64K ? {1'b0, Z_PTR_IN[15:1]}
                                    : {2'b00, Z_PTR_IN[14:1]};
    assign target_readable = (word_addr < unread_start);
    assign store_hit  = STORE_INSTR_IN && (state_r == fspc_pkg::FSPC_ARMED);
    assign load_sig_hit = LOAD_INSTR_IN && sig_arm_r
                          && (arm_cnt_r > (`FSPC_STORE_WINDOW - `FSPC_LOAD_WINDOW));
    assign ctrl_wr    = REG_WR_IN && (REG_ADDR_IN == `FSPC_ADDR_CTRL);

    // reset is released through two flops
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // interrupt enable is plain software state
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
            irq_en_r <= 1'b0;
        else if (ctrl_wr)
            irq_en_r <= REG_WDATA_IN[`FSPC_BIT_IRQ_EN];
    end

    // sequencer: arm window, store dispatch, busy hold
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r    <= fspc_pkg::FSPC_IDLE;
            store_en_r <= 1'b0;
            cmd_r      <= 5'h00;
            sig_arm_r  <= 1'b0;
            arm_cnt_r  <= 3'h0;
        end
        else
        begin
            unique case (state_r)
                fspc_pkg::FSPC_IDLE:
                begin
                    // writes without store enable do nothing; with it set, any combo of the other bits arms
                    if (ctrl_wr && REG_WDATA_IN[`FSPC_BIT_STORE_EN])
                    begin
                        state_r    <= fspc_pkg::FSPC_ARMED;
                        store_en_r <= 1'b1;
                        cmd_r      <= REG_WDATA_IN[4:0];
                        sig_arm_r  <= REG_WDATA_IN[`FSPC_BIT_SIG_READ];
                        arm_cnt_r  <= `FSPC_STORE_WINDOW;
                    end
                end
                fspc_pkg::FSPC_ARMED:
                begin
                    if (store_hit && !sig_arm_r && (cmd_r == `FSPC_CMD_ERASE
                        || cmd_r == `FSPC_CMD_WRITE))
                    begin
                        // stay armed-high until the array reports done
                        state_r <= fspc_pkg::FSPC_BUSY;
                    end
                    else if (store_hit || arm_cnt_r == 3'h1)
                    begin
                        // one-shot commands finish at once; unused arm expires
                        state_r    <= fspc_pkg::FSPC_IDLE;
                        store_en_r <= 1'b0;
                        sig_arm_r  <= 1'b0;
                        cmd_r      <= 5'h00;
                        arm_cnt_r  <= 3'h0;
                    end
                    else
                        arm_cnt_r <= arm_cnt_r - 3'h1;
                end
                fspc_pkg::FSPC_BUSY:
                begin
                    if (FLASH_DONE_IN)
                    begin
                        state_r    <= fspc_pkg::FSPC_IDLE;
                        store_en_r <= 1'b0;
                        cmd_r      <= 5'h00;
                        arm_cnt_r  <= 3'h0;
                    end
                end
            endcase
        end
    end

    // section busy: set by erase/write into readable part, cleared by
    // reread (only once idle) or by a buffer fill; set beats clear
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
            busy_flag_r <= 1'b0;
        else if (store_hit && !sig_arm_r && target_readable
                 && (cmd_r == `FSPC_CMD_ERASE || cmd_r == `FSPC_CMD_WRITE))
            busy_flag_r <= 1'b1;
        else if (store_hit && !sig_arm_r
                 && (cmd_r == `FSPC_CMD_REREAD || cmd_r == `FSPC_CMD_FILL))
            busy_flag_r <= 1'b0;
    end

    // flash array strobes and address fields
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            FLASH_ERASE_OUT    <= 1'b0;
            FLASH_WRITE_OUT    <= 1'b0;
            BUF_FILL_OUT       <= 1'b0;
            PAGE_SELECT_OUT    <= 9'h000;
            WORD_INDEX_OUT     <= 7'h00;
            LOAD_SIG_OUT       <= 1'b0;
            LOAD_HIGH_BYTE_OUT <= 1'b0;
        end
        else
        begin
            // signature arm swallows any store
            FLASH_ERASE_OUT <= store_hit && !sig_arm_r && cmd_r == `FSPC_CMD_ERASE;
            FLASH_WRITE_OUT <= store_hit && !sig_arm_r && cmd_r == `FSPC_CMD_WRITE;
            BUF_FILL_OUT    <= store_hit && !sig_arm_r && cmd_r == `FSPC_CMD_FILL;
            // 128-word page: seven word bits above bit 0, page above those
            WORD_INDEX_OUT  <= Z_PTR_IN[7:1];
            if (VARIANT_64K)
                PAGE_SELECT_OUT <= {1'b0, Z_PTR_IN[15:8]};
            else
                PAGE_SELECT_OUT <= {2'b00, Z_PTR_IN[14:8]};
            LOAD_SIG_OUT       <= load_sig_hit;
            LOAD_HIGH_BYTE_OUT <= Z_PTR_IN[0];
        end
    end

    // status outputs
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            SECTION_BLOCKED_OUT <= 1'b0;
            SECTION_READ_OK_OUT <= 1'b0;
            FLASH_READY_IRQ_OUT <= 1'b0;
            BOOT_RESET_ADDR_OUT <= 16'h0000;
        end
        else
        begin
            SECTION_BLOCKED_OUT <= busy_flag_r;
            SECTION_READ_OK_OUT <= !busy_flag_r && target_readable;
            FLASH_READY_IRQ_OUT <= irq_en_r && GLOBAL_IRQ_EN_IN && !store_en_r;
            BOOT_RESET_ADDR_OUT <= boot_start;
        end
    end

    // register read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
            REG_RDATA_OUT <= 8'h00;
        else if (REG_RD_IN)
        begin
            unique case (REG_ADDR_IN)
                `FSPC_ADDR_CTRL:   REG_RDATA_OUT <= {irq_en_r, busy_flag_r, sig_arm_r,
                                                     cmd_r[4:1], store_en_r};
                `FSPC_ADDR_BOOT:   REG_RDATA_OUT <= {6'h00, BOOT_SIZE_FUSE_IN};
                `FSPC_ADDR_SIG_LO: REG_RDATA_OUT <= boot_start[7:0];
                `FSPC_ADDR_SIG_HI: REG_RDATA_OUT <= boot_start[15:8];
                default:           REG_RDATA_OUT <= 8'h00;
            endcase
        end
        else
            REG_RDATA_OUT <= 8'h00;
    end

    // arming a store opens a four-cycle window
    sequence arm_write_s;
        ctrl_wr && REG_WDATA_IN[0] && state_r == fspc_pkg::FSPC_IDLE;
    endsequence
    sequence no_store_s;
        !STORE_INSTR_IN [*4];
    endsequence
    store_expire_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        arm_write_s ##1 no_store_s |=> !store_en_r)
        else $error("store enable did not expire");
    busy_set_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        store_hit && !sig_arm_r && target_readable && cmd_r == `FSPC_CMD_ERASE
        |=> busy_flag_r)
        else $error("busy flag not set by erase");
    busy_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        state_r == fspc_pkg::FSPC_BUSY |-> store_en_r)
        else $error("store enable dropped while busy");
    fill_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        store_hit && !sig_arm_r && cmd_r == `FSPC_CMD_FILL |=> !busy_flag_r)
        else $error("fill did not clear busy");
    sig_quiet_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        store_hit && sig_arm_r |=> !FLASH_ERASE_OUT && !FLASH_WRITE_OUT
        && !BUF_FILL_OUT)
        else $error("store acted during signature arm");
    irq_level_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        irq_en_r && GLOBAL_IRQ_EN_IN && !store_en_r |=> FLASH_READY_IRQ_OUT)
        else $error("ready irq missing");
    blocked_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        busy_flag_r |=> SECTION_BLOCKED_OUT && !SECTION_READ_OK_OUT)
        else $error("readable section not blocked");
    boot_addr_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        VARIANT_64K && BOOT_SIZE_FUSE_IN == 2'b00 |=> BOOT_RESET_ADDR_OUT == 16'h7000)
        else $error("wrong boot reset address");
    // signature arm, a quiet cycle, then a load inside the load window
    sequence sig_arm_s;
        ctrl_wr && REG_WDATA_IN[`FSPC_BIT_SIG_READ] && REG_WDATA_IN[`FSPC_BIT_STORE_EN]
            && state_r == fspc_pkg::FSPC_IDLE;
    endsequence
    sig_window_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        sig_arm_s ##1 !STORE_INSTR_IN ##1 LOAD_INSTR_IN |=> LOAD_SIG_OUT)
        else $error("signature load not served");
    // a reread cannot land while the array is still busy
    reread_refused_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        state_r == fspc_pkg::FSPC_BUSY && busy_flag_r |=> busy_flag_r)
        else $error("busy flag cleared during erase or write");
    // load byte select is pointer bit 0 of the instruction's cycle
    load_byte_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        LOAD_INSTR_IN |=> LOAD_HIGH_BYTE_OUT == $past(Z_PTR_IN[0]))
        else $error("wrong load byte select");
    // fixed section edges; the upper part of each variant is never reported readable
    unread_big_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        VARIANT_64K && Z_PTR_IN[15:1] >= 15'h7000 |=> !SECTION_READ_OK_OUT)
        else $error("upper section reported readable");
    // 32k part: pointer bit 15 must not matter
    unread_small_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        !VARIANT_64K && Z_PTR_IN[14:1] >= 14'h3800 |=> !SECTION_READ_OK_OUT)
        else $error("upper section reported readable");
    // small part boot start for the smallest boot section
    boot_small_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        !VARIANT_64K && BOOT_SIZE_FUSE_IN == 2'h3 |=> BOOT_RESET_ADDR_OUT == 16'h3f00)
        else $error("wrong small boot reset address");
    // word field follows the pointer of the store
    word_index_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        STORE_INSTR_IN |=> WORD_INDEX_OUT == $past(Z_PTR_IN[7:1]))
        else $error("wrong word index");
    // page select skips the seven word bits and pointer bit 0
    page_big_a: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n_r)
        STORE_INSTR_IN && VARIANT_64K |=> PAGE_SELECT_OUT[7:0] == $past(Z_PTR_IN[15:8]))
        else $error("wrong page select");
endmodule

// file: logic/fspc_map.svh
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
// register indices on the plain register port
`define FSPC_ADDR_CTRL      4'h0
`define FSPC_ADDR_BOOT      4'h1
`define FSPC_ADDR_SIG_LO    4'h2
`define FSPC_ADDR_SIG_HI    4'h3
// control/status field positions
`define FSPC_BIT_IRQ_EN     7
`define FSPC_BIT_BUSY       6
`define FSPC_BIT_SIG_READ   5
`define FSPC_BIT_REREAD     4
`define FSPC_BIT_LOCKSET    3
`define FSPC_BIT_PG_WRITE   2
`define FSPC_BIT_PG_ERASE   1
`define FSPC_BIT_STORE_EN   0
`define FSPC_CTRL_RESET     8'h00
// command codes in the low five bits
`define FSPC_CMD_FILL       5'h01
`define FSPC_CMD_ERASE      5'h03
`define FSPC_CMD_WRITE      5'h05
`define FSPC_CMD_LOCK       5'h09
`define FSPC_CMD_REREAD     5'h11
// arming windows in clock cycles
`define FSPC_STORE_WINDOW   3'h4
`define FSPC_LOAD_WINDOW    3'h3
// boot section starts, 32k-byte variant
`define FSPC_BOOT32_11      16'h3f00
`define FSPC_BOOT32_10      16'h3e00
`define FSPC_BOOT32_01      16'h3c00
`define FSPC_BOOT32_00      16'h3800
// boot section starts, 64k-byte variant
`define FSPC_BOOT64_11      16'h7e00
`define FSPC_BOOT64_10      16'h7c00
`define FSPC_BOOT64_01      16'h7800
`define FSPC_BOOT64_00      16'h7000
// first word of the section unreadable while writing
`define FSPC_UNREAD32       16'h3800
`define FSPC_UNREAD64       16'h7000
`endif

// file: logic/fspc_pkg.sv
package fspc_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        FSPC_IDLE,
        FSPC_ARMED,
        FSPC_BUSY
    } fspc_state_e;
    // width of a command field
    typedef logic [4:0] fspc_cmd_t;
endpackage

// file: tb/fspc_cpu_model.sv
`timescale 1ns/1ps
// cpu core model: drives the pointer and one-cycle store/load pulses
module fspc_cpu_model (
    // clock
    input  wire logic        clk_in,
    // instruction side
    output logic      [15:0] z_ptr_out,
    output logic             store_out,
    output logic             load_out,
    output logic             gie_out
);
    // the pointer is a cpu register, so it holds between instructions
    initial
    begin
        z_ptr_out = 16'h0000;
        store_out = 1'b0;
        load_out  = 1'b0;
        gie_out   = 1'b0;
    end
    // store: page commands get a zero word index, bit 0 always clear
    task automatic spm(input logic [15:0] z, input logic page);
        @(posedge clk_in);
        z_ptr_out <= page ? {z[15:8], 8'h00} : {z[15:1], 1'b0};
        store_out <= 1'b1;
        @(posedge clk_in);
        store_out <= 1'b0;
    endtask
    // load: bit 0 picks the byte
    task automatic load_instr(input logic [15:0] z);
        @(posedge clk_in);
        z_ptr_out <= z;
        load_out  <= 1'b1;
        @(posedge clk_in);
        load_out  <= 1'b0;
    endtask
    // global interrupt flag, changed on an edge like everything else
    task automatic set_gie(input logic v);
        @(posedge clk_in);
        gie_out <= v;
    endtask
endmodule

// file: tb/fspc_tb_top.sv
`timescale 1ns/1ps
`include "fspc_map.svh"
module flash_self_program_control_tb_top;
    // stimulus and observed nets
    logic        clk = 1'b0;
    logic        arst_n;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [1:0]  fuse;
    logic        done;
    logic [7:0]  rdata, d;
    logic [15:0] z, boot, boot32;
    logic [8:0]  pg32;
    logic        rok32;
    logic        st, ld, gie, ers, pwr, fill, sig, hib, blk, rok, irq;
    logic [8:0]  pg;
    logic [6:0]  wi;
    int          err_total = 0;
    int          n_tests = 0;
    always #2.5 clk = ~clk;
    fspc_cpu_model i_fspc_cpu_model (.clk_in(clk), .z_ptr_out(z), .store_out(st),
        .load_out(ld), .gie_out(gie));
    // signature byte is passed outside the block, so it is tied
    fspc_ctrl #(.VARIANT_64K(1'b1)) i_fspc_ctrl (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .Z_PTR_IN(z), .STORE_INSTR_IN(st), .LOAD_INSTR_IN(ld),
        .GLOBAL_IRQ_EN_IN(gie), .BOOT_SIZE_FUSE_IN(fuse), .SIG_BYTE_IN(8'ha5),
        .FLASH_DONE_IN(done), .FLASH_ERASE_OUT(ers), .FLASH_WRITE_OUT(pwr),
        .BUF_FILL_OUT(fill), .PAGE_SELECT_OUT(pg), .WORD_INDEX_OUT(wi),
        .LOAD_SIG_OUT(sig), .LOAD_HIGH_BYTE_OUT(hib), .SECTION_BLOCKED_OUT(blk),
        .SECTION_READ_OK_OUT(rok), .FLASH_READY_IRQ_OUT(irq), .BOOT_RESET_ADDR_OUT(boot));
    // 32k-byte variant on the same stimulus: boot table, section edge, pointer width
    fspc_ctrl #(.VARIANT_64K(1'b0)) i_fspc_ctrl_32k (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(), .Z_PTR_IN(z), .STORE_INSTR_IN(st), .LOAD_INSTR_IN(ld),
        .GLOBAL_IRQ_EN_IN(gie), .BOOT_SIZE_FUSE_IN(fuse), .SIG_BYTE_IN(8'ha5),
        .FLASH_DONE_IN(done), .FLASH_ERASE_OUT(), .FLASH_WRITE_OUT(),
        .BUF_FILL_OUT(), .PAGE_SELECT_OUT(pg32), .WORD_INDEX_OUT(),
        .LOAD_SIG_OUT(), .LOAD_HIGH_BYTE_OUT(), .SECTION_BLOCKED_OUT(),
        .SECTION_READ_OK_OUT(rok32), .FLASH_READY_IRQ_OUT(), .BOOT_RESET_ADDR_OUT(boot32));
    // compare one value, four-state exact
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // register write: one strobe cycle
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // register read: data only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // array completion pulse
    task automatic finish_op();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        cyc(2);
    endtask
    task automatic t_reset();
        rd_reg(`FSPC_ADDR_CTRL, d);
        check(d, `FSPC_CTRL_RESET);
        rd_reg(4'h7, d);
        check(d, 8'h00);
    endtask
    task automatic t_boot();
        logic [15:0] tab [4];
        logic [15:0] tab32 [4];
        tab = '{16'h7000, 16'h7800, 16'h7c00, 16'h7e00};
        tab32 = '{16'h3800, 16'h3c00, 16'h3e00, 16'h3f00};
        for (int f = 0; f < 4; f++)
        begin
            @(posedge clk);
            fuse <= f[1:0];
            cyc(3);
            check(boot, tab[f]);
            check(boot32, tab32[f]);
        end
    endtask
    // erase in the readable part, refused re-enable, then re-enable
    task automatic t_erase();
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_ERASE});
        i_fspc_cpu_model.spm(16'h1234, 1'b1);
        @(negedge clk);
        check(ers, 1'b1);
        check(pg, 9'h012);
        cyc(2);
        check(blk, 1'b1);
        check(rok, 1'b0);
        rd_reg(`FSPC_ADDR_CTRL, d);
        check(d & 8'h41, 8'h41);
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_REREAD});
        i_fspc_cpu_model.spm(16'h0000, 1'b1);
        cyc(2);
        check(blk, 1'b1);
        finish_op();
        rd_reg(`FSPC_ADDR_CTRL, d);
        check(d & 8'h41, 8'h40);
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_REREAD});
        i_fspc_cpu_model.spm(16'h0000, 1'b1);
        cyc(2);
        check(blk, 1'b0);
    endtask
    // write to the upper section leaves the readable part free
    task automatic t_write_top();
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_WRITE});
        i_fspc_cpu_model.spm(16'he0aa, 1'b1);
        @(negedge clk);
        check(pwr, 1'b1);
        check({pg, wi}, {9'h0e0, 7'h00});
        check(pg32, 9'h060);
        cyc(2);
        check(blk, 1'b0);
        finish_op();
    endtask
    // buffer fill after an erase clears busy
    task automatic t_fill();
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_ERASE});
        i_fspc_cpu_model.spm(16'h0100, 1'b1);
        finish_op();
        check(blk, 1'b1);
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_FILL});
        i_fspc_cpu_model.spm(16'h00ff, 1'b0);
        @(negedge clk);
        check({fill, wi}, {1'b1, 7'h7f});
        cyc(2);
        check(blk, 1'b0);
    endtask
    // arm expires, a late store does nothing
    task automatic t_expire();
        wr_reg(`FSPC_ADDR_CTRL, {3'h0, `FSPC_CMD_FILL});
        cyc(5);
        i_fspc_cpu_model.spm(16'h0002, 1'b0);
        @(negedge clk);
        check(fill, 1'b0);
        rd_reg(`FSPC_ADDR_CTRL, d);
        check(d[0], 1'b0);
    endtask
    // section edge and load byte select
    task automatic t_loads();
        i_fspc_cpu_model.load_instr(16'hdfff);
        @(negedge clk);
        check({sig, hib}, 2'b01);
        cyc(1);
        check(rok, 1'b1);
        i_fspc_cpu_model.load_instr(16'he000);
        cyc(2);
        check({rok, hib}, 2'b00);
        i_fspc_cpu_model.load_instr(16'h6ffe);
        cyc(2);
        check(rok32, 1'b1);
        i_fspc_cpu_model.load_instr(16'h7000);
        cyc(2);
        check(rok32, 1'b0);
        i_fspc_cpu_model.load_instr(16'h8000);
        cyc(2);
        check({rok32, rok}, 2'b11);
    endtask
    // signature arm: load served, store ignored; ordinary code leaves it alone
    task automatic t_sig();
        wr_reg(`FSPC_ADDR_CTRL, 8'h21);
        i_fspc_cpu_model.load_instr(16'h0000);
        @(negedge clk);
        check(sig, 1'b1);
        i_fspc_cpu_model.spm(16'h1000, 1'b1);
        @(negedge clk);
        check({ers, pwr, fill}, 3'b000);
        cyc(5);
    endtask
    // ready interrupt follows enable, global flag and store enable
    task automatic t_irq();
        i_fspc_cpu_model.set_gie(1'b1);
        wr_reg(`FSPC_ADDR_CTRL, 8'h81);
        cyc(2);
        check(irq, 1'b0);
        cyc(5);
        check(irq, 1'b1);
        i_fspc_cpu_model.set_gie(1'b0);
        cyc(2);
        check(irq, 1'b0);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence: reset for three cycles, then the scenarios
    initial
    begin
        arst_n <= 1'b0;
        addr   <= 4'h0;
        wdata  <= 8'h00;
        wr     <= 1'b0;
        rd     <= 1'b0;
        fuse   <= 2'h3;
        done   <= 1'b0;
        cyc(3);
        arst_n <= 1'b1;
        cyc(3);
        t_reset();
        t_boot();
        t_erase();
        t_write_top();
        t_fill();
        t_expire();
        t_loads();
        t_sig();
        t_irq();
        wrap_up();
    end
    // watchdog: the scenarios need well under a thousand cycles
    initial
    begin
        #50000;
        err_total++;
        wrap_up();
    end
endmodule
